// ===== core/sbsc_top.sv
// Purpose: status and control words of a two-port serial communications board
// Assumes: word-addressed register port, read data one cycle after the strobe
// Notes: port-side events arrive as one-cycle pulses from the serial engines
// Behaviour
// R1: port 2 abort completion flag at bit 15
// R2: terminal link activity bits per terminal
// R3: macro mode repeat counter in low byte
// R4: no-protocol reception count, four bcd digits
// R5: echoback disabled status bits 06 and 07
// R6: four-bit macro error code per port
// R7: completion bit 15 flags stored error code
// R8: completion word holds case and step
// R9: restart bits 00 and 01 reinitialise ports
// R10: continuous and single-shot trace control bits
// R11: echoback disable request bits 06 and 07
// R12: macro executing flags at 08 and 12
// R13: step error flags and forced abort bits
// R14: sequence end completion at 10 and 14
// R15: only control bits accept program writes
`timescale 1ns/1ps
`include "sbsc_consts.svh"
module sbsc_top
   import sbsc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic IRQ,
   input wire logic [1:0][7:0] OPERATOR_TERMINAL_ACTIVE,
   input wire logic [1:0][7:0] REPEAT_PRESENT_VALUE,
   input wire logic [1:0] RX_DATA_STROBE,
   input wire logic [1:0] TRACING,
   input wire logic [1:0] ECHOBACK_DISABLED,
   input wire logic [1:0] MACRO_START,
   input wire logic [1:0] MACRO_STEP_DONE,
   input wire logic [1:0][3:0] CASE_NUMBER,
   input wire logic [1:0][3:0] STEP_NUMBER,
   input wire logic [1:0] MACRO_SEQ_END,
   input wire logic [1:0] MACRO_STEP_ERROR,
   input wire logic [1:0] MACRO_ABORT_DONE,
   input wire logic [1:0] MACRO_ERROR,
   input wire logic [1:0][3:0] MACRO_ERROR_CODE,
   output logic [1:0] PORT_RESTART,
   output logic [1:0] CONT_TRACE,
   output logic [1:0] SHOT_TRACE,
   output logic [1:0] ECHOBACK_DISABLE_REQ,
   output logic [1:0] FORCED_ABORT
);
   // one bcd digit step with carry out
   function automatic logic [4:0] bcd_digit_inc(input logic [3:0] d, input logic cin);
      logic [4:0] r;
      r = {1'b0, d};
      if (cin) begin
         if (d == `SBSC_BCD_NINE) r = {1'b1, `SBSC_ZERO4};
         else r = {1'b0, d + `SBSC_BCD_ONE};
      end
      return r;
   endfunction : bcd_digit_inc

   // four-digit bcd increment, wraps 9999 to 0000
   function automatic logic [15:0] bcd_inc(input logic [15:0] v);
      logic [4:0] d0;
      logic [4:0] d1;
      logic [4:0] d2;
      logic [4:0] d3;
      d0 = bcd_digit_inc(v[3:0], 1'b1);
      d1 = bcd_digit_inc(v[7:4], d0[4]);
      d2 = bcd_digit_inc(v[11:8], d1[4]);
      d3 = bcd_digit_inc(v[15:12], d2[4]);
      return {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
   endfunction : bcd_inc

   // activity word contents depend on the port's communications mode
   function automatic logic [15:0] activity_word(input sbsc_mode_t m, input logic [7:0] term,
      input logic [7:0] rpt, input logic [15:0] cnt);
      logic [15:0] r;
      r = `SBSC_ZERO16;
      unique case (m)
         SBSC_MODE_TERMINAL: r = {`SBSC_ZERO8, term}; // R2
         SBSC_MODE_MACRO: r = {`SBSC_ZERO8, rpt}; // R3
         SBSC_MODE_NOPROTO: r = cnt; // R4
         SBSC_MODE_HOST: r = `SBSC_ZERO16;
      endcase
      return r;
   endfunction : activity_word

   // control bit address of a field for a port
   function automatic int ctl_pos(input int base, input int port);
      return base + port * `SBSC_CTL_P2_SHIFT;
   endfunction : ctl_pos

   // completion word: stored flag on top, step and case below, the bits between read zero
   function automatic logic [15:0] completion_word(input logic stored, input logic [3:0] step,
      input logic [3:0] rcase);
      logic [15:0] r;
      r = {`SBSC_ZERO8, step, rcase}; // R8
      r[`SBSC_CMP_STORED] = stored; // R7
      return r;
   endfunction : completion_word

   sbsc_port_if pif [2] ();

   sbsc_mode_t mode [2];
   logic [3:0] mode_reg;
   logic [1:0][15:0] rx_count;
   logic [1:0][7:0] term_flags;
   logic [1:0][7:0] repeat_value;
   // per-port copies of tracker state; an interface array takes no loop-variable index
   logic [1:0] step_err_flag;
   logic [1:0] seq_end_flag;
   logic [1:0] abort_done_flag;
   logic [1:0][3:0] err_code_val;
   logic [1:0] restart_req;
   logic [1:0] ctrace;
   logic [1:0] strace;
   logic [1:0] echo_req;
   logic [1:0] abort_req;
   logic [1:0] is_macro;
   logic [1:0] exec_valid;
   logic [15:0] ctrl_word;
   logic [15:0] err_word;
   logic [15:0] abort_word;
   logic [15:0] next_rdata;
   logic [7:0] ev_all;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_istat;
   logic wr_imask;

   // write decode; status words ignore writes
   assign wr_ctrl = WR && (ADDR == `SBSC_ADDR_CTRL); // R15
   assign wr_mode = WR && (ADDR == `SBSC_ADDR_MODE);
   assign wr_istat = WR && (ADDR == `SBSC_ADDR_IRQ_STAT);
   assign wr_imask = WR && (ADDR == `SBSC_ADDR_IRQ_MASK);

   // mode configuration, two bits per port
   always_ff @(posedge CLOCK) begin
      if (SRST) mode_reg <= `SBSC_MODE_RESET;
      else if (wr_mode) mode_reg <= WDATA[3:0];
   end

   assign mode[0] = sbsc_mode_t'(mode_reg[1:0]);
   assign mode[1] = sbsc_mode_t'(mode_reg[3:2]);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_port
         assign is_macro[g] = (mode[g] == SBSC_MODE_MACRO);
         // executing flag is meaningful only with a macro-capable mode
         assign exec_valid[g] = pif[g].executing & (is_macro[g] | (mode[g] == SBSC_MODE_NOPROTO)); // R12

         // restart is a one-cycle pulse; the bit reads back while it is active
         always_ff @(posedge CLOCK) begin
            if (SRST) restart_req[g] <= 1'b0;
            else restart_req[g] <= wr_ctrl & WDATA[ctl_pos(`SBSC_CTL_RESTART, 0) + g]; // R9
         end

         // trace start/stop levels, honoured only in macro mode
         always_ff @(posedge CLOCK) begin
            if (SRST) begin
               ctrace[g] <= 1'b0;
               strace[g] <= 1'b0;
            end else if (wr_ctrl) begin
               ctrace[g] <= WDATA[`SBSC_CTL_CTRACE + g]; // R10
               strace[g] <= WDATA[`SBSC_CTL_STRACE + g]; // R10
            end
         end

         // echoback disable request
         always_ff @(posedge CLOCK) begin
            if (SRST) echo_req[g] <= 1'b0;
            else if (wr_ctrl) echo_req[g] <= WDATA[`SBSC_CTL_ECHO + g]; // R11
         end

         // forced abort: software set beats the hardware clear on completion
         always_ff @(posedge CLOCK) begin
            if (SRST || restart_req[g]) abort_req[g] <= 1'b0;
            else if (wr_ctrl) abort_req[g] <= WDATA[ctl_pos(`SBSC_CTL_ABORT, g)]; // R13
            else if (MACRO_ABORT_DONE[g]) abort_req[g] <= 1'b0;
         end

         // reception counter counts in bcd, only in no-protocol mode
         always_ff @(posedge CLOCK) begin
            if (SRST || restart_req[g]) rx_count[g] <= `SBSC_ZERO16;
            else if (RX_DATA_STROBE[g] && mode[g] == SBSC_MODE_NOPROTO) rx_count[g] <= bcd_inc(rx_count[g]); // R4
         end

         // terminal flags and repeat counter sampled into flops
         always_ff @(posedge CLOCK) begin
            if (SRST) begin
               term_flags[g] <= `SBSC_ZERO8;
               repeat_value[g] <= `SBSC_ZERO8;
            end else begin
               term_flags[g] <= OPERATOR_TERMINAL_ACTIVE[g]; // R2
               repeat_value[g] <= REPEAT_PRESENT_VALUE[g]; // R3
            end
         end

         sbsc_port u_port (
            .clk(CLOCK),
            .srst(SRST),
            .restart(restart_req[g]),
            .start(MACRO_START[g]),
            .step_done(MACRO_STEP_DONE[g]),
            .case_in(CASE_NUMBER[g]),
            .step_in(STEP_NUMBER[g]),
            .seq_done(MACRO_SEQ_END[g]),
            .step_fail(MACRO_STEP_ERROR[g]),
            .abort_fin(MACRO_ABORT_DONE[g]),
            .err(MACRO_ERROR[g]),
            .err_code_in(MACRO_ERROR_CODE[g]),
            .st(pif[g])
         );

         assign ev_all[`SBSC_EV_P2 * g +: `SBSC_EV_P2] = pif[g].events;

         // plain copies for the read-back loops below
         assign step_err_flag[g] = pif[g].step_err;
         assign seq_end_flag[g] = pif[g].seq_end;
         assign abort_done_flag[g] = pif[g].abort_done;
         assign err_code_val[g] = pif[g].err_code;
      end
   endgenerate

   // control word read-back; step error and end flags read zero outside macro mode, executing flags outside macro and no-protocol mode
   always_comb begin
      ctrl_word = `SBSC_ZERO16;
      for (int p = 0; p < 2; p++) begin
         ctrl_word[`SBSC_CTL_RESTART + p] = restart_req[p]; // R9
         ctrl_word[`SBSC_CTL_CTRACE + p] = ctrace[p]; // R10
         ctrl_word[`SBSC_CTL_STRACE + p] = strace[p]; // R10
         ctrl_word[`SBSC_CTL_ECHO + p] = echo_req[p]; // R11
         ctrl_word[ctl_pos(`SBSC_CTL_EXEC, p)] = exec_valid[p]; // R12
         ctrl_word[ctl_pos(`SBSC_CTL_STEPERR, p)] = step_err_flag[p] & is_macro[p]; // R13
         ctrl_word[ctl_pos(`SBSC_CTL_SEQEND, p)] = seq_end_flag[p] & is_macro[p]; // R14
         ctrl_word[ctl_pos(`SBSC_CTL_ABORT, p)] = abort_req[p]; // R13
      end
   end

   // trace flags, echoback status and both error codes
   always_comb begin
      err_word = `SBSC_ZERO16;
      for (int p = 0; p < 2; p++) begin
         err_word[`SBSC_ERR_TRACE + p] = TRACING[p];
         err_word[`SBSC_ERR_ECHO + p] = ECHOBACK_DISABLED[p] & is_macro[p]; // R5
         err_word[`SBSC_ERR_CODE + p * `SBSC_ERR_CODE_W +: `SBSC_ERR_CODE_W] = err_code_val[p]; // R6
      end
   end

   // abort completion flags in macro mode
   always_comb begin
      abort_word = `SBSC_ZERO16;
      abort_word[`SBSC_ABT_P1] = abort_done_flag[0] & is_macro[0];
      abort_word[`SBSC_ABT_P2] = abort_done_flag[1] & is_macro[1]; // R1
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = `SBSC_ZERO16;
      if (RD) begin
         unique case (ADDR)
            `SBSC_ADDR_ACT1: next_rdata = activity_word(mode[0], term_flags[0], repeat_value[0], rx_count[0]);
            `SBSC_ADDR_ACT2: next_rdata = activity_word(mode[1], term_flags[1], repeat_value[1], rx_count[1]);
            `SBSC_ADDR_ERR: next_rdata = err_word;
            `SBSC_ADDR_CMP1:
               next_rdata = completion_word(pif[0].err_stored, pif[0].step_num, pif[0].case_num); // R7 R8
            `SBSC_ADDR_CMP2:
               next_rdata = completion_word(pif[1].err_stored, pif[1].step_num, pif[1].case_num); // R7 R8
            `SBSC_ADDR_CTRL: next_rdata = ctrl_word;
            `SBSC_ADDR_IRQ_STAT: next_rdata = {`SBSC_ZERO8, irq_status};
            `SBSC_ADDR_IRQ_MASK: next_rdata = {`SBSC_ZERO8, irq_mask};
            `SBSC_ADDR_ABORT: next_rdata = abort_word;
            `SBSC_ADDR_MODE: next_rdata = {12'h000, mode_reg};
            default: next_rdata = `SBSC_ZERO16;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CLOCK) begin
      if (SRST) RDATA <= `SBSC_ZERO16;
      else RDATA <= next_rdata;
   end

   sbsc_irq u_irq (
      .clk(CLOCK),
      .srst(SRST),
      .events(ev_all),
      .wr_stat(wr_istat),
      .wr_mask(wr_imask),
      .wdata(WDATA[7:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(IRQ)
   );

   // control outputs to the serial engines, trace gated by macro mode
   assign PORT_RESTART = restart_req; // R9
   assign CONT_TRACE = ctrace & is_macro; // R10
   assign SHOT_TRACE = strace & is_macro; // R10
   assign ECHOBACK_DISABLE_REQ = echo_req & is_macro; // R11
   assign FORCED_ABORT = abort_req; // R13
endmodule : sbsc_top

// ===== core/sbsc_consts.svh
// Purpose: named offsets, field positions and reset values of the serial board status words
// Assumes: word-addressed register port, 16-bit data
// Notes: all figures used by the logic live here
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH

// word offsets
`define SBSC_ADDR_ACT1 8'hca
`define SBSC_ADDR_ACT2 8'hcb
`define SBSC_ADDR_ERR 8'hcc
`define SBSC_ADDR_CMP1 8'hcd
`define SBSC_ADDR_CMP2 8'hce
`define SBSC_ADDR_CTRL 8'hcf
`define SBSC_ADDR_IRQ_STAT 8'hd0
`define SBSC_ADDR_IRQ_MASK 8'hd1
`define SBSC_ADDR_ABORT 8'hd2
`define SBSC_ADDR_MODE 8'hd3

// control word fields (port 1 position; port 2 one bit up for fields below bit 8, at the given offset for the rest)
`define SBSC_CTL_RESTART 0
`define SBSC_CTL_CTRACE 2
`define SBSC_CTL_STRACE 4
`define SBSC_CTL_ECHO 6
`define SBSC_CTL_EXEC 8
`define SBSC_CTL_STEPERR 9
`define SBSC_CTL_SEQEND 10
`define SBSC_CTL_ABORT 11
`define SBSC_CTL_P2_SHIFT 4
`define SBSC_CTL_W 16

// error/trace word fields
`define SBSC_ERR_TRACE 0
`define SBSC_ERR_ECHO 6
`define SBSC_ERR_CODE 8
`define SBSC_ERR_CODE_W 4

// completion and abort word fields
`define SBSC_CMP_STORED 15
`define SBSC_ABT_P1 7
`define SBSC_ABT_P2 15

// interrupt event layout, port 2 at +4
`define SBSC_EV_SEQEND 0
`define SBSC_EV_ABORT 1
`define SBSC_EV_ERR 2
`define SBSC_EV_STEPERR 3
`define SBSC_EV_W 8
`define SBSC_EV_P2 4

// reset values and bcd limits
`define SBSC_ZERO16 16'h0000
`define SBSC_ZERO8 8'h00
`define SBSC_ZERO4 4'h0
`define SBSC_BCD_NINE 4'h9
`define SBSC_BCD_ONE 4'h1
`define SBSC_MODE_RESET 4'h0

`endif

// ===== core/sbsc_pkg.sv
// Purpose: types shared by the serial board status block
// Assumes: nothing beyond the constants header
// Notes: mode codes follow the board configuration word
package sbsc_pkg;
   typedef enum logic [1:0] {
      SBSC_MODE_HOST = 2'b00,
      SBSC_MODE_NOPROTO = 2'b01,
      SBSC_MODE_MACRO = 2'b10,
      SBSC_MODE_TERMINAL = 2'b11
   } sbsc_mode_t;
endpackage : sbsc_pkg

// ===== core/sbsc_port_if.sv
// Purpose: macro status of one serial port carried to the register bank
// Assumes: single clock
// Notes: prov side is the port tracker, cons side the bank
`timescale 1ns/1ps
interface sbsc_port_if;
   logic executing;
   logic step_err;
   logic seq_end;
   logic abort_done;
   logic [3:0] err_code;
   logic err_stored;
   logic [3:0] case_num;
   logic [3:0] step_num;
   logic [3:0] events;
   modport prov (output executing, step_err, seq_end, abort_done, err_code, err_stored, case_num, step_num,
      events);
   modport cons (input executing, step_err, seq_end, abort_done, err_code, err_stored, case_num, step_num,
      events);
endinterface : sbsc_port_if

// ===== core/sbsc_port.sv
// Purpose: tracks protocol macro execution state of one serial port
// Assumes: event inputs are one-cycle pulses
// Notes: restart wipes all recorded state
`timescale 1ns/1ps
`include "sbsc_consts.svh"
module sbsc_port
   import sbsc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic start,
   input wire logic step_done,
   input wire logic [3:0] case_in,
   input wire logic [3:0] step_in,
   input wire logic seq_done,
   input wire logic step_fail,
   input wire logic abort_fin,
   input wire logic err,
   input wire logic [3:0] err_code_in,
   sbsc_port_if.prov st
);
   // execution flags; a new start clears the previous outcome
   always_ff @(posedge clk) begin
      if (srst || restart) begin
         st.executing <= 1'b0;
         st.seq_end <= 1'b0;
         st.abort_done <= 1'b0;
         st.step_err <= 1'b0;
      end else begin
         st.executing <= start | (st.executing & ~seq_done & ~abort_fin); // R12
         st.seq_end <= seq_done | (st.seq_end & ~start); // R14
         st.abort_done <= abort_fin | (st.abort_done & ~start); // R1
         st.step_err <= step_fail | (st.step_err & ~start); // R13
      end
   end

   // completed case and step numbers
   always_ff @(posedge clk) begin
      if (srst || restart) begin
         st.case_num <= `SBSC_ZERO4;
         st.step_num <= `SBSC_ZERO4;
      end else if (step_done) begin
         st.case_num <= case_in; // R8
         st.step_num <= step_in; // R8
      end
   end

   // error code and its stored flag
   always_ff @(posedge clk) begin
      if (srst || restart) begin
         st.err_code <= `SBSC_ZERO4;
         st.err_stored <= 1'b0;
      end else if (err) begin
         st.err_code <= err_code_in; // R6
         st.err_stored <= 1'b1; // R7
      end
   end

   assign st.events = {step_fail, err, abort_fin, seq_done};
endmodule : sbsc_port

// ===== core/sbsc_irq.sv
// Purpose: sticky event status with mask and one level interrupt
// Assumes: write-one-to-clear status
// Notes: a new event beats a simultaneous clear
`timescale 1ns/1ps
`include "sbsc_consts.svh"
module sbsc_irq
   import sbsc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] events,
   input wire logic wr_stat,
   input wire logic wr_mask,
   input wire logic [7:0] wdata,
   output logic [7:0] status,
   output logic [7:0] mask,
   output logic irq
);
   // set wins over clear so no event is lost
   always_ff @(posedge clk) begin
      if (srst) status <= `SBSC_ZERO8;
      else status <= (status & ~(wr_stat ? wdata : `SBSC_ZERO8)) | events;
   end

   always_ff @(posedge clk) begin
      if (srst) mask <= `SBSC_ZERO8;
      else if (wr_mask) mask <= wdata;
   end

   assign irq = |(status & mask);
endmodule : sbsc_irq

// ===== tb/sbsc_top_assertions.sv
// Purpose: port-level checks of the serial board status block
// Assumes: mode and mask words are mirrored from observed writes
// Notes: bound to sbsc_top at the foot of this file
`timescale 1ns/1ps
module sbsc_checker (
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic IRQ,
   input wire logic [1:0] MACRO_SEQ_END,
   input wire logic [1:0] PORT_RESTART,
   input wire logic [1:0] CONT_TRACE,
   input wire logic [1:0] ECHOBACK_DISABLE_REQ,
   input wire logic [1:0] FORCED_ABORT
);
   logic [3:0] mode;
   logic [7:0] mask;
   logic ctl_wr;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);
   assign ctl_wr = WR && ADDR == 8'hcf;
   // mirror of mode and mask, so gating can be judged from the ports alone
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         mode <= 4'h0;
         mask <= 8'h00;
      end else begin
         if (WR && ADDR == 8'hd3) mode <= WDATA[3:0];
         if (WR && ADDR == 8'hd1) mask <= WDATA[7:0];
      end
   end
   read_idle_zero_a: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (RD && (ADDR < 8'hca || ADDR > 8'hd3) |=> RDATA == 16'h0000)
      else $error("unmapped word read not zero");
   restart_pulse_a: assert property ($past(!SRST) |-> PORT_RESTART == ($past(ctl_wr) ? $past(WDATA[1:0]) : 2'b00))
      else $error("restart pulse does not follow control write");
   abort_set_a: assert property (ctl_wr && WDATA[11] && !WDATA[0] |=> FORCED_ABORT[0])
      else $error("forced abort not taken from control write");
   echo_gate_a: assert property (ECHOBACK_DISABLE_REQ[0] |-> mode[1:0] == 2'b10)
      else $error("echoback disable request outside macro mode");
   trace_gate_a: assert property (CONT_TRACE[1] |-> mode[3:2] == 2'b10)
      else $error("continuous trace outside macro mode");
   irq_event_a: assert property (MACRO_SEQ_END[1] && mode[3:2] == 2'b10 && mask[4] && !(WR && ADDR == 8'hd1)
      |=> IRQ)
      else $error("unmasked sequence end did not raise interrupt");
   irq_masked_a: assert property (mask == 8'h00 |-> !IRQ)
      else $error("interrupt high with all events masked");
endmodule : sbsc_checker

bind sbsc_top sbsc_checker chk (.CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .IRQ(IRQ), .MACRO_SEQ_END(MACRO_SEQ_END), .PORT_RESTART(PORT_RESTART),
   .CONT_TRACE(CONT_TRACE), .ECHOBACK_DISABLE_REQ(ECHOBACK_DISABLE_REQ), .FORCED_ABORT(FORCED_ABORT));

// ===== tb/sbsc_peer.sv
// Purpose: serial engines and terminals behind the two ports
// Assumes: events are one-cycle pulses launched after a clock edge
// Notes: event index 0 rx, 1 start, 2 step done, 3 seq end, 4 step error, 5 abort done, 6 error
`timescale 1ns/1ps
module sbsc_peer (
   input wire logic clk,
   output logic [1:0][7:0] term,
   output logic [1:0][7:0] rpt,
   output logic [1:0] trace,
   output logic [1:0] echo,
   output logic [1:0][3:0] case_n,
   output logic [1:0][3:0] step_n,
   output logic [1:0][3:0] code,
   output logic [6:0][1:0] ev
);
   // quiet engines until the bench asks for activity
   initial begin
      term = '0;
      rpt = '0;
      trace = '0;
      echo = '0;
      case_n = '0;
      step_n = '0;
      code = '0;
      ev = '0;
   end
   // one-cycle event on the ports in m; waits past the edge so results have landed
   task pulse(input int k, input logic [1:0] m);
      @(posedge clk);
      ev[k] <= m;
      @(posedge clk);
      ev[k] <= 2'b00;
      #1;
   endtask : pulse
endmodule : sbsc_peer

// ===== tb/sbsc_top_tb.sv
// Purpose: register-level test of the serial board status block
// Assumes: word register port with read data one cycle after the strobe
// Notes: scenarios run in one sequence; mode word changes between them
`timescale 1ns/1ps
module sbsc_top_tb;
   logic clk, srst, wr, rd, irq;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [1:0] restart, ctrace, strace, echo_req, fabort, trace, echo;
   logic [1:0][7:0] term, rpt;
   logic [1:0][3:0] case_n, step_n, code;
   logic [6:0][1:0] ev;
   int err_count = 0;
   int check_count = 0;

   sbsc_peer peer (.clk(clk), .term(term), .rpt(rpt), .trace(trace), .echo(echo), .case_n(case_n),
      .step_n(step_n), .code(code), .ev(ev));
   sbsc_top dut (.CLOCK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .IRQ(irq), .OPERATOR_TERMINAL_ACTIVE(term), .REPEAT_PRESENT_VALUE(rpt), .RX_DATA_STROBE(ev[0]),
      .TRACING(trace), .ECHOBACK_DISABLED(echo), .MACRO_START(ev[1]), .MACRO_STEP_DONE(ev[2]),
      .CASE_NUMBER(case_n), .STEP_NUMBER(step_n), .MACRO_SEQ_END(ev[3]), .MACRO_STEP_ERROR(ev[4]),
      .MACRO_ABORT_DONE(ev[5]), .MACRO_ERROR(ev[6]), .MACRO_ERROR_CODE(code), .PORT_RESTART(restart),
      .CONT_TRACE(ctrace), .SHOT_TRACE(strace), .ECHOBACK_DISABLE_REQ(echo_req), .FORCED_ABORT(fabort));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task conclude;
      if (err_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe, so sample there
   task rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rd_chk

   // cut a hang short; the sequence needs far fewer cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      conclude();
   end

   initial begin
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      // every word and two unmapped offsets read zero after reset
      for (int a = 'hca; a <= 'hd5; a++) rd_chk(a[7:0], 16'h0000);
      // no-protocol: bcd reception counts across a digit carry
      wr_reg(8'hd3, 16'h0005);
      repeat (12) peer.pulse(0, 2'b01);
      repeat (10) peer.pulse(0, 2'b10);
      rd_chk(8'hca, 16'h0012);
      rd_chk(8'hcb, 16'h0010);
      // terminal link: one activity flag per terminal
      wr_reg(8'hd3, 16'h000f);
      peer.term <= {8'h5a, 8'ha5};
      rd_chk(8'hca, 16'h00a5);
      rd_chk(8'hcb, 16'h005a);
      // macro mode: repeat counter, tracing and echoback status
      wr_reg(8'hd3, 16'h000a);
      peer.rpt <= {8'h3c, 8'hff};
      peer.echo <= 2'b01;
      peer.trace <= 2'b10;
      rd_chk(8'hca, 16'h00ff);
      rd_chk(8'hcb, 16'h003c);
      rd_chk(8'hcc, 16'h0042);
      // status bits of the control word ignore program writes
      wr_reg(8'hcf, 16'hfffc);
      rd_chk(8'hcf, 16'h88fc);
      check({ctrace, strace, echo_req, fabort, 8'h00}, 16'hff00);
      // abort completion clears forced abort on both ports
      peer.pulse(5, 2'b11);
      check({14'h0000, fabort}, 16'h0000);
      rd_chk(8'hd2, 16'h8080);
      wr_reg(8'hcf, 16'h0000);
      wr_reg(8'hd0, 16'h00ff);
      // port 2 sequence: executing, step error, sequence end, interrupt
      peer.pulse(1, 2'b10);
      rd_chk(8'hcf, 16'h1000);
      peer.pulse(4, 2'b10);
      rd_chk(8'hcf, 16'h3000);
      wr_reg(8'hd1, 16'h0010);
      check({15'h0000, irq}, 16'h0000);
      peer.pulse(3, 2'b10);
      rd_chk(8'hcf, 16'h6000);
      check({15'h0000, irq}, 16'h0001);
      rd_chk(8'hd0, 16'h0090);
      wr_reg(8'hd0, 16'h0010);
      check({15'h0000, irq}, 16'h0000);
      rd_chk(8'hd0, 16'h0080);
      // completion word of port 1
      peer.case_n <= {4'h0, 4'h3};
      peer.step_n <= {4'h0, 4'h7};
      peer.pulse(2, 2'b01);
      rd_chk(8'hcd, 16'h0073);
      // macro error codes 0 to 5 on port 1, then one on port 2
      for (int c = 0; c <= 5; c++) begin
         peer.code[0] <= c[3:0];
         peer.pulse(6, 2'b01);
         rd_chk(8'hcc, {4'h0, c[3:0], 8'h42});
      end
      rd_chk(8'hcd, 16'h8073);
      peer.code[1] <= 4'h4;
      peer.pulse(6, 2'b10);
      rd_chk(8'hcc, 16'h4542);
      rd_chk(8'hce, 16'h8000);
      // restarts wipe only their own port
      wr_reg(8'hcf, 16'h0001);
      check({14'h0000, restart}, 16'h0001);
      rd_chk(8'hcd, 16'h0000);
      rd_chk(8'hcc, 16'h4042);
      wr_reg(8'hcf, 16'h0002);
      check({14'h0000, restart}, 16'h0002);
      rd_chk(8'hce, 16'h0000);
      conclude();
   end
endmodule : sbsc_top_tb
